// ===== shared/acc_regs.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

`define ACC_OFS_MUXREF      12'h000
`define ACC_OFS_CSR         12'h004
`define ACC_OFS_DIGITAL_INPUT_DISABLE_0       12'h008
`define ACC_OFS_IRQ_STATUS  12'h00c
`define ACC_OFS_IRQ_MASK    12'h010

`define ACC_MUXREF_MUX_EN   6
`define ACC_MUXREF_DIV_HI   5
`define ACC_MUXREF_DIV_LO   4

`define ACC_CSR_POWER_OFF   7
`define ACC_CSR_REF_SEL     6
`define ACC_CSR_RESULT      5
`define ACC_CSR_FLAG        4
`define ACC_CSR_IRQ_EN      3
`define ACC_CSR_CAPTURE     2
`define ACC_CSR_EVSEL_HI    1
`define ACC_CSR_EVSEL_LO    0

`define ACC_DIDR_POS_OFF    7
`define ACC_DIDR_NEG_OFF    6

`define ACC_IRQ_BIT         0

`define ACC_EVSEL_TOGGLE    2'h0
`define ACC_EVSEL_RESERVED  2'h1
`define ACC_EVSEL_FALL      2'h2
`define ACC_EVSEL_RISE      2'h3

`define ACC_REFSEL_INTERNAL 2'h3
`define ACC_CHANNEL_MAX     5'h0a

`define ACC_RST_BYTE        8'h00
`define ACC_RST_WORD        32'h0000_0000

`endif

// ===== shared/acc_pkg.sv
// types shared by the comparator control block
package acc_pkg;

   typedef logic [1:0] acc_evsel_t;

   typedef struct packed {
      logic       power_off;
      logic       ref_select;
      logic       irq_enable;
      logic       capture_route;
      acc_evsel_t event_sel;
   } acc_ctl_s;

   typedef struct packed {
      logic       mux_enable;
      logic [1:0] divider;
   } acc_muxref_s;

   typedef struct packed {
      logic       use_mux;
      logic [4:0] channel;
   } acc_pos_sel_s;

   typedef struct packed {
      logic       use_ref;
      logic       ref_valid;
      logic [1:0] divider;
   } acc_neg_sel_s;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } acc_apb_req_s;

   typedef enum logic [1:0] {
      ACC_APB_IDLE,
      ACC_APB_ACCESS
   } acc_apb_state_e;

endpackage : acc_pkg

// ===== hw/acc_sync.sv
// two-flop synchroniser for the raw comparator output
`timescale 1ns/10ps
module acc_sync (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic d_raw,
   output logic      q_sync
);

   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;

   always_comb begin
      meta_nxt = d_raw;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign q_sync = sync_r;

endmodule : acc_sync

// ===== hw/acc_top.sv
// analog comparator control, event flag, interrupt and apb register slave
//
// Function
// - result is high while selected positive input exceeds selected negative input
// - raw comparator output is synchronised, two clocks of latency
// - event select: 00 toggle, 01 reserved, 10 falling, 11 rising
// - flag sets when synchronised output shows the selected event
// - flag clears when the processor enters the comparator vector
// - writing one to flag clears it, writing zero leaves it
// - interrupt only while flag, enable and global enable are all set
// - power-off bit switches the comparator off, writable any time
// - capture route on feeds comparator output to timer capture front end
// - capture route off keeps comparator disconnected from timer capture
// - mux enable with converter off selects channel as positive input
// - internal reference select replaces negative pin by internal reference
// - with reference select 11, divider gives full, half, quarter, eighth
// - digital input disable forces pin read to zero and buffer off
`timescale 1ns/10ps
`include "acc_regs.svh"
module acc_top (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              cmp_raw,
   input  wire logic              converter_on,
   input  wire logic [4:0]        channel_field,
   input  wire logic [1:0]        reference_select_field,
   input  wire logic              global_irq_enable,
   input  wire logic              vector_ack,
   input  wire logic              positive_pin_level,
   input  wire logic              negative_pin_level,
   output logic                   cmp_power_off,
   output acc_pkg::acc_pos_sel_s  positive_sel,
   output acc_pkg::acc_neg_sel_s  negative_sel,
   output logic                   capture_in,
   output logic                   irq,
   output logic [7:0]             digital_input_off,
   output logic                   positive_pin_read,
   output logic                   negative_pin_read
);

   // request bundle and comparator samples
   acc_pkg::acc_apb_req_s req;
   logic                  cmp_result;
   logic                  prev_r;
   logic                  prev_nxt;
   logic                  evt;

   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

   acc_sync u_sync (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .d_raw   (cmp_raw),
      .q_sync  (cmp_result)
   );

   // event decode from current and previous sample
   function automatic logic acc_event(input acc_pkg::acc_evsel_t sel, input logic cur, input logic prv);
      logic e;
      e = 1'b0;
      unique case (sel)
         `ACC_EVSEL_TOGGLE:   e = cur ^ prv;
         `ACC_EVSEL_RESERVED: e = 1'b0;
         `ACC_EVSEL_FALL:     e = prv & ~cur;
         `ACC_EVSEL_RISE:     e = cur & ~prv;
      endcase
      return e;
   endfunction : acc_event

   // address match
   function automatic logic acc_hit(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction : acc_hit

   // ------------------------------------------------------------ apb slave
   acc_pkg::acc_apb_state_e st_r;
   acc_pkg::acc_apb_state_e st_nxt;
   logic [31:0]             prdata_r;
   logic [31:0]             prdata_nxt;
   logic                    pready_r;
   logic                    pready_nxt;
   logic                    pslverr_r;
   logic                    pslverr_nxt;
   logic                    wr_en;
   logic                    wr_csr;
   logic                    wr_muxref;
   logic                    wr_didr;
   logic                    wr_istat;
   logic                    wr_imask;
   logic                    mapped;

   acc_pkg::acc_ctl_s       ctl_r;
   acc_pkg::acc_ctl_s       ctl_nxt;
   acc_pkg::acc_muxref_s    mref_r;
   acc_pkg::acc_muxref_s    mref_nxt;
   logic [7:0]              didr_r;
   logic [7:0]              didr_nxt;
   logic                    flag_r;
   logic                    flag_nxt;
   logic [7:0]              csr_rd;
   logic [7:0]              mref_rd;

   assign mapped = acc_hit(req.paddr, `ACC_OFS_MUXREF) | acc_hit(req.paddr, `ACC_OFS_CSR) |
                   acc_hit(req.paddr, `ACC_OFS_DIGITAL_INPUT_DISABLE_0) | acc_hit(req.paddr, `ACC_OFS_IRQ_STATUS) |
                   acc_hit(req.paddr, `ACC_OFS_IRQ_MASK);

   assign wr_en     = req.psel & req.penable & pready_r & req.pwrite & ~pslverr_r;
   assign wr_csr    = wr_en & acc_hit(req.paddr, `ACC_OFS_CSR);
   assign wr_muxref = wr_en & acc_hit(req.paddr, `ACC_OFS_MUXREF);
   assign wr_didr   = wr_en & acc_hit(req.paddr, `ACC_OFS_DIGITAL_INPUT_DISABLE_0);
   assign wr_istat  = wr_en & acc_hit(req.paddr, `ACC_OFS_IRQ_STATUS);
   assign wr_imask  = wr_en & acc_hit(req.paddr, `ACC_OFS_IRQ_MASK);

   always_comb begin
      csr_rd = `ACC_RST_BYTE;
      csr_rd[`ACC_CSR_POWER_OFF] = ctl_r.power_off;
      csr_rd[`ACC_CSR_REF_SEL]   = ctl_r.ref_select;
      csr_rd[`ACC_CSR_RESULT]    = cmp_result;
      csr_rd[`ACC_CSR_FLAG]      = flag_r;
      csr_rd[`ACC_CSR_IRQ_EN]    = ctl_r.irq_enable;
      csr_rd[`ACC_CSR_CAPTURE]   = ctl_r.capture_route;
      csr_rd[`ACC_CSR_EVSEL_HI]  = ctl_r.event_sel[1];
      csr_rd[`ACC_CSR_EVSEL_LO]  = ctl_r.event_sel[0];
      mref_rd = `ACC_RST_BYTE;
      mref_rd[`ACC_MUXREF_MUX_EN] = mref_r.mux_enable;
      mref_rd[`ACC_MUXREF_DIV_HI] = mref_r.divider[1];
      mref_rd[`ACC_MUXREF_DIV_LO] = mref_r.divider[0];
   end

   // answer one cycle after setup, read data taken at setup
   always_comb begin
      st_nxt      = st_r;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      prdata_nxt  = prdata_r;
      unique case (st_r)
         acc_pkg::ACC_APB_IDLE: begin
            if (req.psel & ~req.penable) begin
               st_nxt      = acc_pkg::ACC_APB_ACCESS;
               pready_nxt  = 1'b1;
               pslverr_nxt = ~mapped;
               prdata_nxt  = `ACC_RST_WORD;
               if (acc_hit(req.paddr, `ACC_OFS_CSR)) begin
                  prdata_nxt[7:0] = csr_rd;
               end else if (acc_hit(req.paddr, `ACC_OFS_MUXREF)) begin
                  prdata_nxt[7:0] = mref_rd;
               end else if (acc_hit(req.paddr, `ACC_OFS_DIGITAL_INPUT_DISABLE_0)) begin
                  prdata_nxt[7:0] = didr_r;
               end else if (acc_hit(req.paddr, `ACC_OFS_IRQ_STATUS)) begin
                  prdata_nxt[`ACC_IRQ_BIT] = flag_r;
               end else if (acc_hit(req.paddr, `ACC_OFS_IRQ_MASK)) begin
                  prdata_nxt[`ACC_IRQ_BIT] = ctl_r.irq_enable;
               end
            end
         end
         acc_pkg::ACC_APB_ACCESS: begin
            st_nxt = acc_pkg::ACC_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r      <= acc_pkg::ACC_APB_IDLE;
         prdata_r  <= `ACC_RST_WORD;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

   // ------------------------------------------------------------ control registers
   always_comb begin
      ctl_nxt  = ctl_r;
      mref_nxt = mref_r;
      didr_nxt = didr_r;
      if (wr_csr) begin
         ctl_nxt.power_off     = req.pwdata[`ACC_CSR_POWER_OFF];
         ctl_nxt.ref_select    = req.pwdata[`ACC_CSR_REF_SEL];
         ctl_nxt.irq_enable    = req.pwdata[`ACC_CSR_IRQ_EN];
         ctl_nxt.capture_route = req.pwdata[`ACC_CSR_CAPTURE];
         ctl_nxt.event_sel     = req.pwdata[`ACC_CSR_EVSEL_HI:`ACC_CSR_EVSEL_LO];
      end
      if (wr_imask) begin
         ctl_nxt.irq_enable = req.pwdata[`ACC_IRQ_BIT];
      end
      if (wr_muxref) begin
         mref_nxt.mux_enable = req.pwdata[`ACC_MUXREF_MUX_EN];
         mref_nxt.divider    = req.pwdata[`ACC_MUXREF_DIV_HI:`ACC_MUXREF_DIV_LO];
      end
      if (wr_didr) begin
         didr_nxt = req.pwdata[7:0];
      end
   end

   // ------------------------------------------------------------ event flag
   assign evt = acc_event(ctl_r.event_sel, cmp_result, prev_r);

   always_comb begin
      prev_nxt = cmp_result;
      flag_nxt = flag_r;
      if (vector_ack) begin
         flag_nxt = 1'b0;
      end
      if ((wr_csr & req.pwdata[`ACC_CSR_FLAG]) | (wr_istat & req.pwdata[`ACC_IRQ_BIT])) begin
         flag_nxt = 1'b0;
      end
      if (evt) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctl_r  <= '0;
         mref_r <= '0;
         didr_r <= `ACC_RST_BYTE;
         flag_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         ctl_r  <= ctl_nxt;
         mref_r <= mref_nxt;
         didr_r <= didr_nxt;
         flag_r <= flag_nxt;
         prev_r <= prev_nxt;
      end
   end

   // ------------------------------------------------------------ registered outputs
   acc_pkg::acc_pos_sel_s pos_r;
   acc_pkg::acc_pos_sel_s pos_nxt;
   acc_pkg::acc_neg_sel_s neg_r;
   acc_pkg::acc_neg_sel_s neg_nxt;
   logic                  irq_r;
   logic                  irq_nxt;
   logic                  cap_r;
   logic                  cap_nxt;
   logic                  poff_r;
   logic                  poff_nxt;
   logic                  pos_rd_r;
   logic                  pos_rd_nxt;
   logic                  neg_rd_r;
   logic                  neg_rd_nxt;
   logic [7:0]            dio_r;
   logic [7:0]            dio_nxt;

   always_comb begin
      irq_nxt         = flag_r & ctl_r.irq_enable & global_irq_enable;
      cap_nxt         = ctl_r.capture_route & cmp_result;
      poff_nxt        = ctl_r.power_off;
      pos_nxt.use_mux = mref_r.mux_enable & ~converter_on;
      pos_nxt.channel = channel_field;
      neg_nxt.use_ref   = ctl_r.ref_select;
      neg_nxt.ref_valid = reference_select_field == `ACC_REFSEL_INTERNAL;
      neg_nxt.divider   = mref_r.divider;
      dio_nxt    = didr_r;
      pos_rd_nxt = positive_pin_level & ~didr_r[`ACC_DIDR_POS_OFF];
      neg_rd_nxt = negative_pin_level & ~didr_r[`ACC_DIDR_NEG_OFF];
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_r    <= 1'b0;
         cap_r    <= 1'b0;
         poff_r   <= 1'b0;
         pos_r    <= '0;
         neg_r    <= '0;
         dio_r    <= `ACC_RST_BYTE;
         pos_rd_r <= 1'b0;
         neg_rd_r <= 1'b0;
      end else begin
         irq_r    <= irq_nxt;
         cap_r    <= cap_nxt;
         poff_r   <= poff_nxt;
         pos_r    <= pos_nxt;
         neg_r    <= neg_nxt;
         dio_r    <= dio_nxt;
         pos_rd_r <= pos_rd_nxt;
         neg_rd_r <= neg_rd_nxt;
      end
   end

   assign irq               = irq_r;
   assign capture_in        = cap_r;
   assign cmp_power_off     = poff_r;
   assign positive_sel      = pos_r;
   assign negative_sel      = neg_r;
   assign digital_input_off = dio_r;
   assign positive_pin_read = pos_rd_r;
   assign negative_pin_read = neg_rd_r;

   // ------------------------------------------------------------ checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_sync_latency;
      ##2 cmp_result == $past(cmp_raw, 2);
   endproperty
   a_sync_latency: assert property (p_sync_latency) else $error("result not two clocks behind raw");

   property p_toggle_sets;
      (ctl_r.event_sel == `ACC_EVSEL_TOGGLE && cmp_result != prev_r) |=> flag_r;
   endproperty
   a_toggle_sets: assert property (p_toggle_sets) else $error("toggle did not set flag");

   property p_rise_fall;
      (ctl_r.event_sel == `ACC_EVSEL_RISE && $rose(cmp_result)) or
      (ctl_r.event_sel == `ACC_EVSEL_FALL && $fell(cmp_result)) |=> flag_r;
   endproperty
   a_rise_fall: assert property (p_rise_fall) else $error("edge event did not set flag");

   property p_reserved_quiet;
      (ctl_r.event_sel == `ACC_EVSEL_RESERVED && !flag_r) |=> !flag_r;
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved mode set flag");

   property p_vector_clear;
      (vector_ack && !evt) |=> !flag_r;
   endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("vector entry did not clear flag");

   property p_w1c;
      (wr_csr && req.pwdata[`ACC_CSR_FLAG] && !evt) |=> !flag_r;
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one left flag set");

   property p_w0_keeps;
      (wr_csr && !req.pwdata[`ACC_CSR_FLAG] && flag_r && !vector_ack) |=> flag_r;
   endproperty
   a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared flag");

   property p_irq_gate;
      ##1 irq == ($past(flag_r) && $past(ctl_r.irq_enable) && $past(global_irq_enable));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by flag and enables");

   property p_capture_off;
      !ctl_r.capture_route |=> !capture_in;
   endproperty
   a_capture_off: assert property (p_capture_off) else $error("capture path not disconnected");

   property p_pin_off;
      didr_r[`ACC_DIDR_POS_OFF] |=> !positive_pin_read;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("disabled pin read not zero");

endmodule : acc_top

// ===== bench/acc_partner.sv
// model of the analog comparator and the timer capture front end
`timescale 1ns/10ps
module acc_partner (
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   input  wire logic                  cmp_power_off,
   input  wire acc_pkg::acc_pos_sel_s positive_sel,
   input  wire acc_pkg::acc_neg_sel_s negative_sel,
   input  wire logic                  capture_in,
   input  wire logic                  capture_irq_en,
   input  wire logic [11:0]           pin_pos_mv,
   input  wire logic [11:0]           pin_neg_mv,
   output logic                       cmp_raw,
   output logic [7:0]                 capture_count
);
   logic [11:0] pos_mv;
   logic [11:0] neg_mv;
   logic        cap_q;
   // channel n sits at n times 100 mv
   always_comb begin
      pos_mv = positive_sel.use_mux ? 12'(positive_sel.channel) * 12'h064 : pin_pos_mv;
      neg_mv = pin_neg_mv;
      if (negative_sel.use_ref) begin
         neg_mv = negative_sel.ref_valid ? (12'ha00 >> negative_sel.divider) : 12'hfff;
      end
      cmp_raw = ~cmp_power_off & (pos_mv > neg_mv);
   end
   // timer capture counts rising edges only with its own enable
   always_ff @(posedge clk_sys) begin
      cap_q <= capture_in;
      if (sys_rst) begin
         capture_count <= 8'h00;
      end else if (capture_in & ~cap_q & capture_irq_en) begin
         capture_count <= capture_count + 8'h01;
      end
   end
endmodule : acc_partner

// ===== bench/tb.sv
// self-checking testbench for the comparator control block
`timescale 1ns/10ps
`include "acc_regs.svh"
module tb;
   localparam logic [11:0] r_mux = `ACC_OFS_MUXREF;
   localparam logic [11:0] r_csr = `ACC_OFS_CSR;
   localparam logic [11:0] r_did = `ACC_OFS_DIGITAL_INPUT_DISABLE_0;
   localparam logic [11:0] r_sts = `ACC_OFS_IRQ_STATUS;
   localparam logic [11:0] r_msk = `ACC_OFS_IRQ_MASK;
   localparam logic [59:0] reg_list = {r_mux, r_csr, r_did, r_sts, r_msk};
   localparam logic [9:0]  chan_list = {5'h0a, 5'h03};
   logic                  clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, cmp_raw;
   logic [11:0]           paddr, pin_pos_mv, pin_neg_mv;
   logic [31:0]           pwdata, prdata, rdat;
   logic                  converter_on, global_irq_enable, vector_ack, rerr, cap_en;
   logic                  positive_pin_level, negative_pin_level, cmp_power_off;
   logic                  capture_in, irq, positive_pin_read, negative_pin_read;
   logic [4:0]            channel_field;
   logic [1:0]            reference_select_field;
   logic [7:0]            digital_input_off, cap_cnt;
   acc_pkg::acc_pos_sel_s positive_sel;
   acc_pkg::acc_neg_sel_s negative_sel;
   int                    failures, comparisons;

   acc_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_raw(cmp_raw), .converter_on(converter_on), .channel_field(channel_field),
      .reference_select_field(reference_select_field), .global_irq_enable(global_irq_enable),
      .vector_ack(vector_ack), .positive_pin_level(positive_pin_level),
      .negative_pin_level(negative_pin_level), .cmp_power_off(cmp_power_off),
      .positive_sel(positive_sel), .negative_sel(negative_sel), .capture_in(capture_in), .irq(irq),
      .digital_input_off(digital_input_off), .positive_pin_read(positive_pin_read),
      .negative_pin_read(negative_pin_read));

   acc_partner cmp (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmp_power_off(cmp_power_off),
      .positive_sel(positive_sel), .negative_sel(negative_sel), .capture_in(capture_in),
      .capture_irq_en(cap_en), .pin_pos_mv(pin_pos_mv), .pin_neg_mv(pin_neg_mv),
      .cmp_raw(cmp_raw), .capture_count(cap_cnt));

   always #50 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask : rd

   task automatic edge_to(input logic [11:0] mv);
      pin_pos_mv <= mv;
      cyc(6);
   endtask : edge_to

   task automatic final_report;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   initial begin
      cyc(20000);
      failures++;
      final_report();
   end

   initial begin
      {clk_sys, psel, penable, pwrite, paddr, pwdata, converter_on, channel_field} = '0;
      {reference_select_field, global_irq_enable, vector_ack, cap_en} = '0;
      {positive_pin_level, negative_pin_level, pin_pos_mv} = '0;
      pin_neg_mv = 12'h064;
      sys_rst = 1'b1;
      cyc(20);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) rd(reg_list[12*i +: 12], '1, 0);
      rd(12'h014, '1, 0);
      chk(rerr, 1'b1);
      for (int s = 0; s < 4; s++) begin
         wr(r_csr, 32'h10 | s);
         edge_to(12'h0c8);
         rd(r_csr, 32'h30, (s == 0 || s == 3) ? 32'h30 : 32'h20);
         wr(r_csr, 32'h10 | s);
         edge_to(12'h000);
         rd(r_csr, 32'h30, (s == 0 || s == 2) ? 32'h10 : 32'h00);
      end
      wr(r_csr, 32'h18);
      global_irq_enable <= 1'b1;
      edge_to(12'h0c8);
      chk(irq, 1'b1);
      wr(r_csr, 32'h08);
      rd(r_sts, '1, 32'h1);
      global_irq_enable <= 1'b0;
      cyc(2);
      chk(irq, 1'b0);
      global_irq_enable <= 1'b1;
      wr(r_msk, 32'h0);
      cyc(2);
      chk(irq, 1'b0);
      wr(r_msk, 32'h1);
      cyc(2);
      chk(irq, 1'b1);
      vector_ack <= 1'b1;
      cyc(1);
      vector_ack <= 1'b0;
      cyc(3);
      chk(irq, 1'b0);
      edge_to(12'h000);
      wr(r_sts, 32'h1);
      rd(r_sts, '1, 32'h0);
      wr(r_csr, 32'h00);
      chk(cap_cnt, 8'h00);
      cap_en <= 1'b1;
      wr(r_csr, 32'h04);
      repeat (2) begin
         edge_to(12'h0c8);
         edge_to(12'h000);
      end
      chk(cap_cnt, 8'h02);
      wr(r_csr, 32'h00);
      edge_to(12'h0c8);
      chk(capture_in, 1'b0);
      chk(cap_cnt, 8'h02);
      pin_pos_mv <= 12'h000;
      wr(r_mux, 32'h40);
      for (int i = 0; i < 2; i++) begin
         channel_field <= chan_list[5*i +: 5];
         cyc(4);
         chk({26'h0, positive_sel}, {26'h0, 1'b1, chan_list[5*i +: 5]});
         rd(r_csr, 32'h20, 32'h20);
      end
      converter_on <= 1'b1;
      cyc(4);
      chk(positive_sel.use_mux, 1'b0);
      rd(r_csr, 32'h20, 32'h00);
      rd(r_mux, '1, 32'h40);
      pin_pos_mv <= 12'h2bc;
      reference_select_field <= 2'h3;
      wr(r_csr, 32'h40);
      for (int d = 0; d < 4; d++) begin
         wr(r_mux, 32'(d) << 4);
         cyc(4);
         chk({28'h0, negative_sel}, {28'h0, 2'h3, 2'(d)});
         rd(r_csr, 32'h20, (d > 1) ? 32'h20 : 32'h00);
      end
      reference_select_field <= 2'h1;
      cyc(2);
      chk(negative_sel.ref_valid, 1'b0);
      wr(r_csr, 32'h00);
      cyc(1);
      chk(negative_sel.use_ref, 1'b0);
      cyc(2);
      rd(r_csr, 32'h20, 32'h20);
      wr(r_csr, 32'h80);
      cyc(1);
      chk(cmp_power_off, 1'b1);
      cyc(4);
      rd(r_csr, '1, 32'h90);
      wr(r_csr, 32'h00);
      {positive_pin_level, negative_pin_level} <= 2'h3;
      wr(r_did, 32'h80);
      cyc(1);
      chk({positive_pin_read, negative_pin_read}, 2'h1);
      wr(r_did, 32'hc0);
      cyc(1);
      chk({positive_pin_read, negative_pin_read}, 2'h0);
      chk(digital_input_off, 8'hc0);
      wr(12'h014, 32'hff);
      chk(rerr, 1'b1);
      final_report();
   end
endmodule : tb
